/* File: src/port_pin_config_ext_irq.sv */
// pin configuration and pad control for ports 0..2, external interrupt logic for port 0
//
// Chosen here: strobed register access.
module port_pin_config_ext_irq
    import port_cfg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire bus_req_type bus,
    output logic      [7:0]  rdata,
    input  wire logic [7:0]  p0_in,
    output logic      [7:0]  p0_out,
    output logic      [7:0]  p0_oe,
    output logic      [7:0]  p0_pullup,
    input  wire logic [2:0]  p1_in,
    output logic      [2:0]  p1_out,
    output logic      [2:0]  p1_oe,
    output logic      [2:0]  p1_pullup,
    output logic      [2:0]  p1_analog,
    input  wire logic [7:0]  p2_in,
    output logic      [7:0]  p2_out,
    output logic      [7:0]  p2_oe,
    output logic      [7:0]  p2_pullup,
    output logic      [7:0]  p2_analog,
    input  wire logic [7:0]  p0_data,
    input  wire logic [2:0]  p1_data,
    input  wire logic [7:0]  p2_data,
    input  wire logic        timer_a_output,
    input  wire logic        buzzer_output,
    input  wire logic        pwm_output,
    input  wire logic        timer_d_output,
    output logic             timer_a_capture_in,
    output logic             timer_a_clock_in,
    output logic      [7:0]  pin_state,
    output logic      [7:0]  irq_request
);
    state_type st_reg;
    state_type st_next;

    // two-bit field of a config byte
    function automatic logic [1:0] fld(input logic [7:0] r, input int i);
        fld = r[2*i +: 2];
    endfunction : fld

    // field selecting the mode of a port 0 pin
    function automatic logic [1:0] p0_mode(input logic [7:0] hi, input logic [7:0] lo,
                                           input int pin);
        p0_mode = (pin >= 4) ? fld(hi, pin - 4) : fld(lo, pin);
    endfunction : p0_mode

    logic [7:0] fall;
    logic [7:0] in_mode;
    logic [7:0] edge_set;
    logic [7:0] s4_reg;
    assign pin_state = st_reg.s3;

    // falling edge once stages two and three agree low after a high
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_edge
            assign in_mode[g] = (p0_mode(st_reg.p0_hi, st_reg.p0_lo, g) < MODE_PP);
            assign fall[g]    = s4_reg[g] && !st_reg.s3[g] && !st_reg.s2[g];
        end
    endgenerate

    // next state: bus writes, pending set wins over clear
    always_comb
    begin
        st_next       = st_reg;
        st_next.s1    = p0_in;
        st_next.s2    = st_reg.s1;
        st_next.s3    = st_reg.s2;
        st_next.rdata = 8'h00;
        if (bus.wr)
        begin
            if (bus.addr == IRQ_ENABLE_ADDR)
                st_next.irq_en = bus.wdata & IRQ_MASK;
            else if (bus.addr == P0_CFG_HI_ADDR)
                st_next.p0_hi = bus.wdata & P0_HI_MASK;
            else if (bus.addr == P0_CFG_LO_ADDR)
                st_next.p0_lo = bus.wdata & P0_LO_MASK;
            else if (bus.addr == IRQ_PEND_ADDR)
                st_next.pend = st_reg.pend & bus.wdata;
            else if (bus.addr == P1_CFG_ADDR)
                st_next.p1 = bus.wdata & P1_MASK;
            else if (bus.addr == P2_CFG_LO_ADDR)
                st_next.p2_lo = bus.wdata;
            else if (bus.addr == P2_CFG_HI_ADDR)
                st_next.p2_hi = bus.wdata;
        end
        // edge sets pending when input and enabled
        st_next.pend = st_next.pend | edge_set;
        if (bus.rd)
        begin
            if (bus.addr == IRQ_ENABLE_ADDR)
                st_next.rdata = st_reg.irq_en;
            else if (bus.addr == P0_CFG_HI_ADDR)
                st_next.rdata = st_reg.p0_hi;
            else if (bus.addr == P0_CFG_LO_ADDR)
                st_next.rdata = st_reg.p0_lo;
            else if (bus.addr == IRQ_PEND_ADDR)
                st_next.rdata = st_reg.pend;
            else if (bus.addr == P1_CFG_ADDR)
                st_next.rdata = st_reg.p1;
            else if (bus.addr == P2_CFG_LO_ADDR)
                st_next.rdata = st_reg.p2_lo;
            else if (bus.addr == P2_CFG_HI_ADDR)
                st_next.rdata = st_reg.p2_hi;
            else
                st_next.rdata = 8'h00;
        end
    end

    // edge set term: stage three holds the settled level, stage four is the old one
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            s4_reg <= 8'hFF;
        else
            s4_reg <= (st_reg.s2 == st_reg.s3) ? st_reg.s3 : s4_reg;
    end
    assign edge_set = fall & in_mode & st_reg.irq_en & IRQ_MASK;

    // state register
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_reg       <= '0;
            st_reg.s1    <= 8'hFF;
            st_reg.s2    <= 8'hFF;
            st_reg.s3    <= 8'hFF;
        end
        else
            st_reg <= st_next;
    end

    assign rdata       = st_reg.rdata;
    assign irq_request = st_reg.pend;

    // port 0 pad control
    always_comb
    begin
        logic [1:0] m;
        m = 2'h0;
        for (int i = 0; i < 8; i++)
        begin
            m            = p0_mode(st_reg.p0_hi, st_reg.p0_lo, i);
            p0_pullup[i] = (m == MODE_IN_PU) && IRQ_MASK[i];
            p0_out[i]    = p0_data[i];
            p0_oe[i]     = (m == MODE_PP) && IRQ_MASK[i];
            if (m == MODE_ALT && IRQ_MASK[i])
            begin
                case (i)
                    6: begin p0_out[i] = timer_a_output; p0_oe[i] = 1'b1; end
                    4: begin p0_out[i] = pwm_output;     p0_oe[i] = 1'b1; end
                    3: begin p0_out[i] = buzzer_output;  p0_oe[i] = 1'b1; end
                    default: begin p0_out[i] = 1'b0; p0_oe[i] = !p0_data[i]; end
                endcase
            end
        end
    end

    // port 1 and port 2 pad control
    always_comb
    begin
        logic [1:0] m;
        m = 2'h0;
        for (int i = 0; i < 3; i++)
        begin
            m            = fld(st_reg.p1, i);
            p1_out[i]    = p1_data[i];
            p1_oe[i]     = (m == MODE_PP);
            p1_pullup[i] = (m == MODE_IN_PU);
            p1_analog[i] = (m == MODE_ALT);
        end
        for (int i = 0; i < 8; i++)
        begin
            m            = (i >= 4) ? fld(st_reg.p2_hi, i - 4) : fld(st_reg.p2_lo, i);
            p2_out[i]    = p2_data[i];
            p2_oe[i]     = (m == MODE_PP);
            p2_analog[i] = (m == MODE_ALT);
            p2_pullup[i] = (m == MODE_IN_PU) && (i != 0) && (i != 4) && (i != 5)
                           && (i != 1) && (i != 2);
            if (i == 0 && m == MODE_IN_PU)
            begin
                p2_out[i] = timer_d_output;
                p2_oe[i]  = 1'b1;
            end
            if ((i == 4 || i == 5 || i == 1 || i == 2) && m == MODE_IN_PU)
                p2_analog[i] = 1'b1;
        end
    end

    // timer inputs from port 1 pins in input modes
    assign timer_a_capture_in = !st_reg.p1[3] && p1_in[1];
    assign timer_a_clock_in   = !st_reg.p1[1] && p1_in[0];

    // pending clears by written zero unless an edge arrives
    a_pend_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus.wr && bus.addr == IRQ_PEND_ADDR && !bus.wdata[0] && !edge_set[0]
        |=> !st_reg.pend[0]) else $error("pending not cleared");
    a_edge_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        edge_set[0] |=> st_reg.pend[0]) else $error("pending not set");
    a_irq_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        !st_reg.irq_en[1] && !st_reg.pend[1] && !(bus.wr && bus.addr == IRQ_PEND_ADDR)
        |=> !st_reg.pend[1]) else $error("disabled line set");
    a_p0_alt: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_hi[5:4] == MODE_ALT |-> p0_oe[6] && p0_out[6] == timer_a_output)
        else $error("pin6 alt wrong");
    // timer D output on port 2 pin 0
    a_p2_tmr: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p2_lo[1:0] == MODE_IN_PU |-> p2_oe[0] && p2_out[0] == timer_d_output)
        else $error("pin0 timer d wrong");
    a_pend_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus.rd && bus.addr == IRQ_PEND_ADDR |=> rdata == $past(st_reg.pend))
        else $error("pending read wrong");

    // a written one keeps a pending bit
    a_pend_keep: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus.wr && bus.addr == IRQ_PEND_ADDR && bus.wdata[6] && st_reg.pend[6]
        |=> st_reg.pend[6]) else $error("pending not kept");

    // enable write lands masked
    a_en_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        bus.wr && bus.addr == IRQ_ENABLE_ADDR
        |=> st_reg.irq_en == ($past(bus.wdata) & IRQ_MASK)) else $error("enable write wrong");

    // output mode pin never sets pending
    a_out_noset: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_lo[7:6] == MODE_PP && !st_reg.pend[3] |=> !st_reg.pend[3])
        else $error("output pin set pending");

    // pin 4 alternate drives pwm
    a_p0_pwm: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_hi[1:0] == MODE_ALT |-> p0_oe[4] && p0_out[4] == pwm_output)
        else $error("pin4 alt wrong");

    // pin 3 alternate drives buzzer
    a_p0_buzz: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_lo[7:6] == MODE_ALT |-> p0_oe[3] && p0_out[3] == buzzer_output)
        else $error("pin3 alt wrong");

    // pin 5 open-drain pulls low only
    a_p0_od5: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_hi[3:2] == MODE_ALT |-> !p0_out[5] && p0_oe[5] == !p0_data[5])
        else $error("pin5 open-drain wrong");

    // pin 1 open-drain pulls low only
    a_p0_od1: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_lo[3:2] == MODE_ALT |-> !p0_out[1] && p0_oe[1] == !p0_data[1])
        else $error("pin1 open-drain wrong");

    // pin 0 open-drain pulls low only
    a_p0_od0: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p0_lo[1:0] == MODE_ALT |-> !p0_out[0] && p0_oe[0] == !p0_data[0])
        else $error("pin0 open-drain wrong");

    // port 1 pin 2 comparator input
    a_p1_cmp: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p1[5:4] == MODE_ALT |-> p1_analog[2] && !p1_oe[2])
        else $error("port1 pin2 analog wrong");

    // capture input follows pin in input mode
    a_p1_cap: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p1[3:2] == MODE_IN |-> timer_a_capture_in == p1_in[1])
        else $error("capture input wrong");

    // clock input follows pin in pull-up input mode
    a_p1_clk: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p1[1:0] == MODE_IN_PU |-> timer_a_clock_in == p1_in[0])
        else $error("clock input wrong");

    // port 2 pin 7 analog channel
    a_p2_analog_channel_7: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p2_hi[7:6] == MODE_ALT |-> p2_analog[7] && !p2_oe[7])
        else $error("port2 pin7 analog wrong");

    // port 2 pin 5 comparator input
    a_p2_cmp5: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p2_hi[3:2] == MODE_IN_PU |-> p2_analog[5] && !p2_pullup[5])
        else $error("port2 pin5 comparator wrong");

    // port 2 pin 4 comparator input
    a_p2_cmp4: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p2_hi[1:0] == MODE_IN_PU |-> p2_analog[4] && !p2_pullup[4])
        else $error("port2 pin4 comparator wrong");

    // port 2 pin 3 analog channel
    a_p2_analog_channel_3: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_reg.p2_lo[7:6] == MODE_ALT |-> p2_analog[3] && !p2_oe[3])
        else $error("port2 pin3 analog wrong");
endmodule : port_pin_config_ext_irq

/* File: src/port_cfg_pkg.sv */
// constants and types for the port pin configuration block
package port_cfg_pkg;
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'hE3;
    localparam logic [7:0] P0_CFG_HI_ADDR  = 8'hE4;
    localparam logic [7:0] P0_CFG_LO_ADDR  = 8'hE5;
    localparam logic [7:0] IRQ_PEND_ADDR   = 8'hE6;
    localparam logic [7:0] P1_CFG_ADDR     = 8'hE7;
    localparam logic [7:0] P2_CFG_LO_ADDR  = 8'hE9;
    localparam logic [7:0] P2_CFG_HI_ADDR  = 8'hE8;
    localparam logic [7:0] CFG_RESET       = 8'h00;
    // implemented bit masks
    localparam logic [7:0] P0_HI_MASK      = 8'h3F;
    localparam logic [7:0] P0_LO_MASK      = 8'hCF;
    localparam logic [7:0] IRQ_MASK        = 8'h7B;
    localparam logic [7:0] P1_MASK         = 8'h3F;
    // field encodings
    localparam logic [1:0] MODE_IN         = 2'h0;
    localparam logic [1:0] MODE_IN_PU      = 2'h1;
    localparam logic [1:0] MODE_PP         = 2'h2;
    localparam logic [1:0] MODE_ALT        = 2'h3;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_type;

    typedef struct packed {
        logic [7:0] irq_en;
        logic [7:0] p0_hi;
        logic [7:0] p0_lo;
        logic [7:0] pend;
        logic [7:0] p1;
        logic [7:0] p2_lo;
        logic [7:0] p2_hi;
        logic [7:0] rdata;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
    } state_type;
endpackage : port_cfg_pkg

/* File: tb/pin_partner.sv */
// pad model for port 0: pad driver, outside driver, pull-up or drifting pin
module pin_partner (
    input  wire logic       core_clk,
    input  wire logic [7:0] p0_out,
    input  wire logic [7:0] p0_oe,
    input  wire logic [7:0] p0_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] p0_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_reg;
    // an undriven pin without pull-up drifts so a stale level never passes
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            p0_in[i] = p0_oe[i] ? p0_out[i] : ext_en[i] ? ext_lvl[i] :
                       p0_pullup[i] ? 1'b1 : ~last_reg[i];
    end
    // last level seen on each pin
    always_ff @(posedge core_clk) last_reg <= p0_in;
endmodule : pin_partner

/* File: tb/testbench.sv */
// self-checking bench for the port pin configuration block
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s exp %h got %h", what, (exp), (got)); end end
module testbench
    import port_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, sys_rst, ta_out, bz_out, pwm_out, td_out, cap_in, clk_in;
    bus_req_type bus;
    logic [7:0]  rdata, p0_in, p0_out, p0_oe, p0_pu, p0_data, p2_in, p2_data, irq_req;
    logic [7:0]  p2_out, p2_oe, p2_pu, p2_an, ext_lvl, ext_en, pin_st;
    logic [2:0]  p1_in, p1_data, p1_oe, p1_pu, p1_an, p1_out;
    int          errors, samples_checked, cycles;
    // device under test
    port_pin_config_ext_irq dut (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pu),
        .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup(p1_pu), .p1_analog(p1_an),
        .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pullup(p2_pu), .p2_analog(p2_an),
        .p0_data(p0_data), .p1_data(p1_data), .p2_data(p2_data), .timer_a_output(ta_out),
        .buzzer_output(bz_out), .pwm_output(pwm_out), .timer_d_output(td_out),
        .timer_a_capture_in(cap_in), .timer_a_clock_in(clk_in), .pin_state(pin_st),
        .irq_request(irq_req));
    // pins outside the device
    pin_partner pads (.core_clk(core_clk), .p0_out(p0_out), .p0_oe(p0_oe),
        .p0_pullup(p0_pu), .ext_en(ext_en), .ext_lvl(ext_lvl), .p0_in(p0_in));
    // closing report and verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    // one-cycle read, data judged in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        `CHK(what, exp, rdata)
    endtask : rd
    // reset values, masks, read-only holes and unmapped place
    task automatic t_regs;
        logic [7:0] ad [7] = '{IRQ_ENABLE_ADDR, P0_CFG_HI_ADDR, P0_CFG_LO_ADDR,
                              IRQ_PEND_ADDR, P1_CFG_ADDR, P2_CFG_LO_ADDR, P2_CFG_HI_ADDR};
        logic [7:0] mk [7] = '{8'h7B, 8'h3F, 8'hCF, 8'h00, 8'h3F, 8'hFF, 8'hFF};
        for (int i = 0; i < 7; i++)
            rd(ad[i], 8'h00, "reset value");
        for (int i = 0; i < 7; i++)
        begin
            wr(ad[i], 8'hFF);
            rd(ad[i], mk[i], "masked value");
            wr(ad[i], 8'h00);
        end
        wr(8'hE2, 8'hFF);
        rd(8'hE2, 8'h00, "unmapped");
        $display("register test done");
    endtask : t_regs
    // every port 0 mode on all six pins
    task automatic t_p0;
        logic [7:0] eoe [4] = '{8'h00, 8'h00, 8'h7B, 8'h5A};
        logic [1:0] c;
        for (int m = 0; m < 4; m++)
        begin
            c = m[1:0];
            wr(P0_CFG_HI_ADDR, {2'b00, c, c, c});
            wr(P0_CFG_LO_ADDR, {c, 2'b00, c, c});
            #1;
            `CHK("p0_oe", eoe[m], p0_oe & 8'h7B)
            `CHK("p0_pullup", (c == 2'h1) ? 8'h7B : 8'h00, p0_pu & 8'h7B)
            if (m == 2)
                `CHK("p0_out", 8'h21, p0_out & 8'h7B)
            if (m == 3)
                `CHK("p0_out", 8'h50, p0_out & 8'h7B)
        end
        $display("port 0 mode test done");
    endtask : t_p0
    // every port 1 and port 2 mode
    task automatic t_p12;
        logic [1:0] c;
        for (int m = 0; m < 4; m++)
        begin
            c = m[1:0];
            wr(P1_CFG_ADDR, {2'b00, c, c, c});
            wr(P2_CFG_HI_ADDR, {c, 2'b00, c, c});
            // analog setting of port 2 pin 3, as needed with the op-amp on
            wr(P2_CFG_LO_ADDR, {c, 4'h0, c});
            #1;
            `CHK("p1_oe", {3{c == 2'h2}}, p1_oe)
            `CHK("p1_pullup", {3{c == 2'h1}}, p1_pu)
            `CHK("p1_analog", {3{c == 2'h3}}, p1_an)
            if (c < 2'h2)
                `CHK("capture clock", 2'b10, {cap_in, clk_in})
            `CHK("p2_oe", (c == 2'h2) ? 8'hB9 : {7'h00, c == 2'h1}, p2_oe & 8'hB9)
            `CHK("p2_pullup", (c == 2'h1) ? 8'h88 : 8'h00, p2_pu & 8'hB9)
            `CHK("p2_analog", (c == 2'h3) ? 8'h89 : 8'h00, p2_an & 8'h89)
            `CHK("p2_analog", (c == 2'h3) ? 8'hB9 : (c == 2'h1) ? 8'h30 : 8'h00, p2_an & 8'hB9)
            if (c == 2'h2)
            begin
                `CHK("p1_out", p1_data, p1_out)
                `CHK("p2_out", 8'h38, p2_out & 8'hB9)
            end
            if (c == 2'h1)
                `CHK("p2_out", td_out, p2_out[0])
        end
        $display("port 1 and 2 mode test done");
    endtask : t_p12
    // falling edges in input, pull-up and output mode, enabled and masked
    task automatic t_irq;
        p0_data <= 8'hFF;
        wr(P0_CFG_HI_ADDR, 8'h10);
        wr(P0_CFG_LO_ADDR, 8'h80);
        wr(IRQ_ENABLE_ADDR, 8'h79);
        repeat (6) @(posedge core_clk);
        wr(IRQ_PEND_ADDR, 8'h00);
        ext_lvl <= 8'hBC;
        p0_data <= 8'hF7;
        repeat (8) @(posedge core_clk);
        rd(IRQ_PEND_ADDR, 8'h41, "pending");
        `CHK("irq_request", 8'h41, irq_req & 8'h7B)
        `CHK("pin_state", 8'hB4, pin_st)
        wr(IRQ_PEND_ADDR, 8'hFF);
        rd(IRQ_PEND_ADDR, 8'h41, "pending kept");
        wr(IRQ_PEND_ADDR, 8'hBF);
        rd(IRQ_PEND_ADDR, 8'h01, "pending cleared");
        $display("interrupt test done");
    endtask : t_irq
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // hang guard
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            wrap_up();
        end
    end
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        bus = '0;
        {ta_out, bz_out, pwm_out, td_out} = 4'b1010;
        p0_data = 8'hA5;
        p1_in = 3'b010;
        p1_data = 3'b101;
        p2_in = 8'h5A;
        p2_data = 8'h3C;
        ext_en = 8'hFF;
        ext_lvl = 8'hFF;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_p0();
        t_p12();
        t_irq();
        wrap_up();
    end
endmodule : testbench
